/* File: hw/amcd_top.sv */
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "amcd_defs.svh"
// Overview of operation
// - Distortion above programmed clip level drives that channel's assigned status pin
// - Each channel's clip indication routes to diagnostic or standby pin by own bit
// - Temperature and load reports leave the diagnostic pin when disabled; bytes still latch
// - Clip indications blocked below the 10 V level unless lower level enabled
// - Reduced bias only with both pairs low gain and line-driver selected
// - Address strap chooses legacy mode or one of several bus addresses
// - Address held below 6 V; decode without 6 V supply is invalid
// - Legacy standby pin is off/mute/operating; amplifier starts at once
// - Legacy mute/operating transitions paced by a 15 ms timer
// - Legacy operating-to-off applies hard mute within 400 us then shuts down
// - Bus mode standby low: low quiescent current, bus lines unloaded
// - Bus mode standby high: operating, power-on reset, diagnostic pin low
// - Amp start bit starts amplifier, clears reset flag, releases diagnostic pin
// - Soft mute per pair ramps that pair to mute over 15 ms
// - Hard mute mutes all within 400 us; release is 15 ms soft unmute
// - Bus mode standby off after start: hard mute first, then shutdown
// - Diagnostic status bits latch on failure until the host reads them
// - Latches clear only after all five status bytes are read
// - Diagnostic pin follows present fault, released when failure disappears
// - Supply-follow bit disconnects ripple filter from common-mode output
// - Power-on reset clears every instruction bit
// - Clip field 00 is 2 %, 01 5 %, 10 10 %, 11 disabled
module amcd_top #(
  parameter int unsigned SOFT_MUTE_CYC = `AMCD_SOFT_MUTE_US * `AMCD_CLK_MHZ,
  parameter int unsigned HARD_MUTE_CYC = `AMCD_HARD_MUTE_US * `AMCD_CLK_MHZ
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [1:0] standby_mode_pin,
  input wire logic [2:0] addr_strap_pin,
  input wire logic vp_above_10v,
  input wire logic vp_above_low,
  input wire logic vp_above_6v,
  input wire logic [3:0] clip_2pct,
  input wire logic [3:0] clip_5pct,
  input wire logic [3:0] clip_10pct,
  input wire logic temp_warn,
  input wire logic [3:0] load_fault,
  output logic diag_pin_oe_n,
  output logic stb_clip_oe_n,
  output logic amp_enable,
  output logic hard_mute,
  output logic mute_front,
  output logic mute_rear,
  output logic bias_reduced,
  output logic ripple_filter_pin,
  output logic low_quiescent,
  output logic bus_lines_loaded,
  output logic gain_front_low,
  output logic gain_rear_low,
  output logic [6:0] bus_addr,
  output logic addr_valid,
  output logic legacy_mode
);

  amcd_pkg::amcd_state_s st_reg;
  amcd_pkg::amcd_state_s st_next;

  // ****************************************
  // Synchronised pin view
  // ****************************************
  logic [1:0] stb_pin;
  logic [2:0] strap;
  logic vp10, vplow, vp6, temp_s;
  logic [3:0] c2, c5, c10, load_s;
  assign {stb_pin, strap, vp10, vplow, vp6, c2, c5, c10, temp_s, load_s} = st_reg.sync2;

  // ****************************************
  // Combinational next state
  // ****************************************
  logic [3:0] clip_ch;
  logic [3:0] clip_route;
  logic clip_ok;
  logic pin_off, pin_mute, stb_hi, powered, stb_rise;
  logic hard_req;
  logic [1:0] mute_tgt;
  logic [19:0] lim;
  logic diag_drive, stb_drive;
  logic wb_req, wr_en;
  logic [3:0] idx;
  logic rd_db, clr_db;
  logic [2:0] db_num;
  logic [`AMCD_NUM_DB-1:0][7:0] db_evt;
  logic [`AMCD_NUM_DB-1:0][7:0] db_keep;

  always_comb
  begin
    st_next = st_reg;
    st_next.sync1 = {standby_mode_pin, addr_strap_pin, vp_above_10v, vp_above_low, vp_above_6v,
                     clip_2pct, clip_5pct, clip_10pct, temp_warn, load_fault};
    st_next.sync2 = st_reg.sync1;

    pin_off = (stb_pin == 2'h0);
    pin_mute = (stb_pin == 2'h1);
    stb_hi = stb_pin[0] | stb_pin[1];
    stb_rise = stb_hi & ~st_reg.stb_hi_d;
    powered = ~pin_off;
    st_next.stb_hi_d = stb_hi;

    // Address strap, frozen while the supply is below 6 V
    if (vp6)
    begin
      st_next.legacy = (strap == `AMCD_STRAP_LEGACY);
      unique case (strap)
        `AMCD_STRAP_100K: st_next.bus_addr = `AMCD_ADDR_100K;
        `AMCD_STRAP_30K: st_next.bus_addr = `AMCD_ADDR_30K;
        `AMCD_STRAP_10K: st_next.bus_addr = `AMCD_ADDR_10K;
        `AMCD_STRAP_FORCED: st_next.bus_addr = `AMCD_ADDR_FORCED;
        default: st_next.bus_addr = `AMCD_ADDR_OPEN;
      endcase
      st_next.addr_valid = 1'b1;
    end
    if (stb_rise & ~st_reg.legacy & ~vp6)
    begin
      st_next.addr_valid = 1'b0;
    end

    // Wishbone decode
    wb_req = wb_cyc_i & wb_stb_i & ~st_reg.wb_ack;
    idx = wb_adr_i[5:2];
    wr_en = wb_req & wb_we_i & wb_sel_i[0] & ~st_reg.legacy & stb_hi;
    rd_db = wb_req & ~wb_we_i & (idx >= `AMCD_IDX_DB1) & (idx <= `AMCD_IDX_DB5);
    db_num = 3'(idx - `AMCD_IDX_DB1);
    st_next.wb_ack = wb_req;
    st_next.wb_dat = '0;
    if (wb_req & ~wb_we_i)
    begin
      if (idx <= `AMCD_IDX_IB5)
        st_next.wb_dat = {24'h000000, st_reg.ib[idx[2:0]]};
      else if (idx <= `AMCD_IDX_DB5)
        st_next.wb_dat = {24'h000000, st_reg.db[db_num]};
      else if (idx == `AMCD_IDX_STATE)
        st_next.wb_dat = {16'h0000, st_reg.muted, st_reg.run_state, st_reg.legacy, st_reg.addr_valid,
                          2'h0, st_reg.bus_addr, 1'b0};
    end
    // Instruction bytes, each at its own word, first through fifth
    if (wr_en & (idx <= `AMCD_IDX_IB5))
    begin
      st_next.ib[idx[2:0]] = wb_dat_i[7:0];
    end
    if (stb_rise & ~st_reg.legacy)
    begin
      for (int i = 0; i < `AMCD_NUM_IB; i++)
        st_next.ib[i] = `AMCD_BYTE_ZERO;
    end

    // Clip detection with level select and supply blocking
    unique case (st_reg.ib[1][`AMCD_IB2_CLIP_LVL_LO +: 2])
      `AMCD_CLIP_2PCT: clip_ch = c2;
      `AMCD_CLIP_5PCT: clip_ch = c5;
      `AMCD_CLIP_10PCT: clip_ch = c10;
      default: clip_ch = 4'h0;
    endcase
    clip_ok = vp10 | (st_reg.ib[0][`AMCD_IB1_LOWV_CLIP] & vplow);
    clip_ch = clip_ch & {4{clip_ok & st_reg.amp_on}};
    // Channels 1..4 map to route bits 5, 3, 6, 4
    clip_route = {st_reg.ib[0][4], st_reg.ib[0][6], st_reg.ib[0][3], st_reg.ib[0][5]};

    // Status latches; clear comes only after the fifth byte of an ordered read
    clr_db = rd_db & (idx == `AMCD_IDX_DB5) & (st_reg.rd_seq == 3'h4);
    if (rd_db)
    begin
      if (db_num == st_reg.rd_seq)
        st_next.rd_seq = (st_reg.rd_seq == 3'h4) ? 3'h0 : 3'(st_reg.rd_seq + 3'h1);
      else
        st_next.rd_seq = (db_num == 3'h0) ? 3'h1 : 3'h0;
    end
    else if (wb_req)
    begin
      st_next.rd_seq = 3'h0;
    end
    db_evt = '0;
    for (int c = 0; c < 4; c++)
    begin
      db_evt[c][`AMCD_DB_LOAD_BIT] = load_s[c];
      db_evt[c][`AMCD_DB_CLIP_BIT] = clip_ch[c];
    end
    db_evt[`AMCD_DB_TEMP_BYTE][`AMCD_DB_TEMP_BIT] = temp_s;
    db_keep = '0;
    db_keep[`AMCD_DB_POR_BYTE][`AMCD_DB_POR_BIT] = 1'b1;
    for (int b = 0; b < `AMCD_NUM_DB; b++)
      st_next.db[b] = (clr_db ? (st_reg.db[b] & db_keep[b]) : st_reg.db[b]) | db_evt[b];
    // Reset flag: set by bus power-up, cleared by the start bit
    if (wr_en & (idx == `AMCD_IDX_IB1) & wb_dat_i[`AMCD_IB1_AMP_START])
      st_next.db[`AMCD_DB_POR_BYTE][`AMCD_DB_POR_BIT] = 1'b0;
    if (stb_rise & ~st_reg.legacy)
      st_next.db[`AMCD_DB_POR_BYTE][`AMCD_DB_POR_BIT] = 1'b1;

    // Power sequencing
    st_next.sd_cnt = '0;
    unique case (st_reg.run_state)
      amcd_pkg::AMCD_OFF:
      begin
        if (st_reg.legacy ? powered : (stb_hi & ~stb_rise & st_reg.ib[0][`AMCD_IB1_AMP_START]))
          st_next.run_state = amcd_pkg::AMCD_RUN;
      end
      amcd_pkg::AMCD_RUN:
      begin
        if (pin_off | (~st_reg.legacy & ~st_reg.ib[0][`AMCD_IB1_AMP_START]))
          st_next.run_state = amcd_pkg::AMCD_SHUTDOWN;
      end
      amcd_pkg::AMCD_SHUTDOWN:
      begin
        st_next.sd_cnt = 15'(st_reg.sd_cnt + 15'h1);
        if (st_reg.sd_cnt == 15'(HARD_MUTE_CYC - 1))
          st_next.run_state = amcd_pkg::AMCD_OFF;
      end
      default: st_next.run_state = amcd_pkg::AMCD_OFF;
    endcase
    st_next.amp_on = (st_next.run_state != amcd_pkg::AMCD_OFF);

    // Mute ramps per pair: hard mute uses the short time, all else the soft time
    hard_req = (st_reg.run_state == amcd_pkg::AMCD_SHUTDOWN) |
               (~st_reg.legacy & st_reg.ib[1][`AMCD_IB2_HARD_MUTE]);
    mute_tgt[0] = hard_req | (st_reg.legacy ? pin_mute : st_reg.ib[1][`AMCD_IB2_SOFT_FRONT]);
    mute_tgt[1] = hard_req | (st_reg.legacy ? pin_mute : st_reg.ib[1][`AMCD_IB2_SOFT_REAR]);
    st_next.hard_mute = hard_req;
    lim = 20'(SOFT_MUTE_CYC - 1);
    for (int p = 0; p < 2; p++)
    begin
      lim = (mute_tgt[p] & hard_req) ? 20'(HARD_MUTE_CYC - 1) : 20'(SOFT_MUTE_CYC - 1);
      if (st_reg.run_state == amcd_pkg::AMCD_OFF)
      begin
        st_next.muted[p] = 1'b1;
        st_next.mute_cnt[p] = '0;
      end
      else if (mute_tgt[p] != st_reg.muted[p])
      begin
        if (st_reg.mute_cnt[p] >= lim)
        begin
          st_next.muted[p] = mute_tgt[p];
          st_next.mute_cnt[p] = '0;
        end
        else
          st_next.mute_cnt[p] = 20'(st_reg.mute_cnt[p] + 20'h1);
      end
      else
        st_next.mute_cnt[p] = '0;
    end

    // Pin drivers (enable low pulls the pin low)
    diag_drive = (~st_reg.legacy & st_reg.db[`AMCD_DB_POR_BYTE][`AMCD_DB_POR_BIT]) |
                 (|(clip_ch & ~clip_route)) |
                 (temp_s & ~st_reg.ib[1][`AMCD_IB2_NO_TEMP_DIAG]) |
                 ((|load_s) & ~st_reg.ib[1][`AMCD_IB2_NO_LOAD_DIAG]);
    stb_drive = |(clip_ch & clip_route);
    st_next.diag_oe_n = ~diag_drive;
    st_next.stb_clip_oe_n = ~stb_drive;

    st_next.bias_reduced = st_reg.ib[2][`AMCD_IB3_GAIN_FRONT] & st_reg.ib[2][`AMCD_IB3_GAIN_REAR] &
                           st_reg.ib[3][`AMCD_IB4_LINE_DRV];
    st_next.ripple_disc = st_reg.ib[3][`AMCD_IB4_SUPPLY_FOLLOW];
    st_next.gain_front_low = st_reg.ib[2][`AMCD_IB3_GAIN_FRONT];
    st_next.gain_rear_low = st_reg.ib[2][`AMCD_IB3_GAIN_REAR];
    st_next.low_iq = ~powered;
    st_next.bus_loaded = ~st_reg.legacy & stb_hi;
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      st_reg <= '0;
      st_reg.muted <= 2'h3;
      st_reg.diag_oe_n <= 1'b1;
      st_reg.stb_clip_oe_n <= 1'b1;
      st_reg.low_iq <= 1'b1;
      st_reg.legacy <= 1'b1;
      st_reg.run_state <= amcd_pkg::AMCD_OFF;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_o = st_reg.wb_dat;
  assign wb_ack_o = st_reg.wb_ack;
  assign diag_pin_oe_n = st_reg.diag_oe_n;
  assign stb_clip_oe_n = st_reg.stb_clip_oe_n;
  assign amp_enable = st_reg.amp_on;
  assign hard_mute = st_reg.hard_mute;
  assign mute_front = st_reg.muted[0];
  assign mute_rear = st_reg.muted[1];
  assign bias_reduced = st_reg.bias_reduced;
  assign ripple_filter_pin = st_reg.ripple_disc;
  assign low_quiescent = st_reg.low_iq;
  assign bus_lines_loaded = st_reg.bus_loaded;
  assign gain_front_low = st_reg.gain_front_low;
  assign gain_rear_low = st_reg.gain_rear_low;
  assign bus_addr = st_reg.bus_addr;
  assign addr_valid = st_reg.addr_valid;
  assign legacy_mode = st_reg.legacy;

  // ****************************************
  // Assertions
  // ****************************************
  a_bias_reduced: assert property (@(posedge clock) disable iff (rst)
    bias_reduced |-> (st_reg.ib[2][`AMCD_IB3_GAIN_FRONT] | $past(st_reg.ib[2][`AMCD_IB3_GAIN_FRONT])))
    else $error("reduced bias without low front gain");

  localparam int HARD_MUTE_SHORT = 2;

  a_shutdown_time: assert property (@(posedge clock) disable iff (rst)
    (st_reg.run_state == amcd_pkg::AMCD_RUN && st_next.run_state == amcd_pkg::AMCD_SHUTDOWN) |=>
      ##1 (hard_mute throughout (##[1:HARD_MUTE_SHORT] 1'b1)))
    else $error("hard mute not held during shutdown");

  a_shutdown_end: assert property (@(posedge clock) disable iff (rst)
    (st_reg.run_state == amcd_pkg::AMCD_SHUTDOWN && st_reg.sd_cnt == 15'(HARD_MUTE_CYC - 1)) |=>
      !amp_enable)
    else $error("amplifier still on after hard mute time");

  a_start_needs_bit: assert property (@(posedge clock) disable iff (rst)
    ($rose(amp_enable) && !legacy_mode) |-> $past(st_reg.ib[0][`AMCD_IB1_AMP_START]))
    else $error("bus mode start without start bit");

  a_por_diag_low: assert property (@(posedge clock) disable iff (rst)
    (!legacy_mode && st_reg.db[`AMCD_DB_POR_BYTE][`AMCD_DB_POR_BIT]) |=> !diag_pin_oe_n)
    else $error("diagnostic pin released while reset flag set");

  a_partial_read: assert property (@(posedge clock) disable iff (rst)
    (rd_db && !clr_db && st_reg.db[0][`AMCD_DB_LOAD_BIT]) |=> st_reg.db[0][`AMCD_DB_LOAD_BIT])
    else $error("status latch lost without full read");

  a_latch_holds: assert property (@(posedge clock) disable iff (rst)
    (st_reg.db[`AMCD_DB_TEMP_BYTE][`AMCD_DB_TEMP_BIT] && !clr_db) |=>
      st_reg.db[`AMCD_DB_TEMP_BYTE][`AMCD_DB_TEMP_BIT])
    else $error("temperature latch dropped without read");

  a_quiet_standby: assert property (@(posedge clock) disable iff (rst)
    (!st_reg.legacy && !stb_hi) |=> (!bus_lines_loaded && low_quiescent))
    else $error("bus loaded in standby");

  a_clip_disabled: assert property (@(posedge clock) disable iff (rst)
    (st_reg.ib[1][`AMCD_IB2_CLIP_LVL_LO +: 2] == 2'h3) |-> (clip_ch == 4'h0))
    else $error("clip reported with detection disabled");

  a_clip_low_supply: assert property (@(posedge clock) disable iff (rst)
    (!vp10 && !st_reg.ib[0][`AMCD_IB1_LOWV_CLIP]) |-> (clip_ch == 4'h0))
    else $error("clip reported below supply level");

  a_ack_one_cycle: assert property (@(posedge clock) disable iff (rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");

endmodule

/* File: hw/amcd_defs.svh */
`ifndef AMCD_DEFS_SVH
`define AMCD_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define AMCD_CLK_MHZ 50
`define AMCD_SOFT_MUTE_US 15000
`define AMCD_HARD_MUTE_US 400

// ****************************************
// Register word indices (byte address = 4 * index)
// ****************************************
`define AMCD_IDX_IB1 4'h0
`define AMCD_IDX_IB5 4'h4
`define AMCD_IDX_DB1 4'h5
`define AMCD_IDX_DB5 4'h9
`define AMCD_IDX_STATE 4'ha
`define AMCD_NUM_IB 5
`define AMCD_NUM_DB 5

// ****************************************
// Field positions
// ****************************************
`define AMCD_IB1_AMP_START 0
`define AMCD_IB1_LOWV_CLIP 7
`define AMCD_IB2_HARD_MUTE 0
`define AMCD_IB2_SOFT_REAR 1
`define AMCD_IB2_SOFT_FRONT 2
`define AMCD_IB2_NO_LOAD_DIAG 4
`define AMCD_IB2_NO_TEMP_DIAG 5
`define AMCD_IB2_CLIP_LVL_LO 6
`define AMCD_IB3_GAIN_REAR 5
`define AMCD_IB3_GAIN_FRONT 6
`define AMCD_IB4_LINE_DRV 2
`define AMCD_IB4_SUPPLY_FOLLOW 7
`define AMCD_DB_LOAD_BIT 0
`define AMCD_DB_CLIP_BIT 1
`define AMCD_DB_POR_BIT 7
`define AMCD_DB_TEMP_BIT 0
`define AMCD_DB_POR_BYTE 1
`define AMCD_DB_TEMP_BYTE 4

// ****************************************
// Encodings and reset values
// ****************************************
`define AMCD_CLIP_2PCT 2'h0
`define AMCD_CLIP_5PCT 2'h1
`define AMCD_CLIP_10PCT 2'h2
`define AMCD_STRAP_LEGACY 3'h0
`define AMCD_STRAP_100K 3'h1
`define AMCD_STRAP_30K 3'h2
`define AMCD_STRAP_10K 3'h3
`define AMCD_STRAP_FORCED 3'h4
`define AMCD_ADDR_100K 7'h6e
`define AMCD_ADDR_30K 7'h6f
`define AMCD_ADDR_10K 7'h6a
`define AMCD_ADDR_FORCED 7'h6d
`define AMCD_ADDR_OPEN 7'h6c
`define AMCD_BYTE_ZERO 8'h00
`define AMCD_SYNC_W 25

`endif

/* File: hw/amcd_pkg.sv */
`include "amcd_defs.svh"

package amcd_pkg;

  // ****************************************
  // Power sequencing states
  // ****************************************
  typedef enum logic [1:0]
  {
    AMCD_OFF = 2'h0,
    AMCD_RUN = 2'h1,
    AMCD_SHUTDOWN = 2'h3
  } amcd_run_e;

  typedef logic [7:0] amcd_byte_t;

  // ****************************************
  // Whole module state
  // ****************************************
  typedef struct packed {
    logic [`AMCD_SYNC_W-1:0] sync1;
    logic [`AMCD_SYNC_W-1:0] sync2;
    amcd_run_e run_state;
    logic [`AMCD_NUM_IB-1:0][7:0] ib;
    logic [`AMCD_NUM_DB-1:0][7:0] db;
    logic [2:0] rd_seq;
    logic [1:0][19:0] mute_cnt;
    logic [1:0] muted;
    logic [14:0] sd_cnt;
    logic stb_hi_d;
    logic [6:0] bus_addr;
    logic addr_valid;
    logic legacy;
    logic wb_ack;
    logic [31:0] wb_dat;
    logic amp_on;
    logic hard_mute;
    logic bias_reduced;
    logic ripple_disc;
    logic diag_oe_n;
    logic stb_clip_oe_n;
    logic low_iq;
    logic bus_loaded;
    logic gain_front_low;
    logic gain_rear_low;
  } amcd_state_s;

endpackage

/* File: dv/amcd_host.sv */
`timescale 1ns/1ps
// ****************************************
// Host controller on the register bus
// ****************************************
module amcd_host (
  input wire logic clock,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [5:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i
);
  logic [3:0] sel_val = 4'h1;

  initial
  begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 6'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
  end

  // Request held until ack is sampled; idle cycle after so ack can drop
  task automatic acc(input logic we, input logic [3:0] idx, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'h0};
    wb_sel_i <= sel_val;
    wb_dat_i <= {24'h000000, d};
    do
      @(posedge clock);
    while (wb_ack_o !== 1'b1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_dat_i <= ~wb_dat_i;
    @(posedge clock);
  endtask

  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    logic [7:0] q;
    acc(1'b1, idx, d, q);
  endtask

  // Always the whole set of five bytes, first to fifth
  task automatic wr5(input logic [39:0] b);
    for (int i = 0; i < 5; i++)
      wr(4'(i), b[39-8*i -: 8]);
  endtask

  task automatic rd(input logic [3:0] idx, output logic [7:0] q);
    acc(1'b0, idx, 8'h00, q);
  endtask
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`include "amcd_defs.svh"
module tb_top;
  // Short mute counts keep the run brief; HARD stays below SOFT
  localparam int SOFT = 40;
  localparam int HARD = 8;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [5:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [1:0] standby_mode_pin = 2'h0;
  logic [2:0] addr_strap_pin = `AMCD_STRAP_10K;
  logic vp_above_10v = 1'b1;
  logic vp_above_low = 1'b0;
  logic vp_above_6v = 1'b0;
  logic [3:0] clip_2pct = 4'h0;
  logic [3:0] clip_5pct = 4'h0;
  logic [3:0] clip_10pct = 4'h0;
  logic temp_warn = 1'b0;
  logic [3:0] load_fault = 4'h0;
  logic diag_pin_oe_n, stb_clip_oe_n, amp_enable, hard_mute, mute_front, mute_rear, bias_reduced;
  logic ripple_filter_pin, low_quiescent, bus_lines_loaded, gain_front_low, gain_rear_low;
  logic [6:0] bus_addr;
  logic addr_valid, legacy_mode;
  int n_mismatch = 0;
  int cmp_count = 0;
  logic [7:0] q;
  logic [7:0] b1;
  logic [2:0] strap_tab [5] = '{`AMCD_STRAP_100K, `AMCD_STRAP_30K, `AMCD_STRAP_10K, `AMCD_STRAP_FORCED, 3'h7};
  logic [6:0] addr_tab [5] = '{`AMCD_ADDR_100K, `AMCD_ADDR_30K, `AMCD_ADDR_10K, `AMCD_ADDR_FORCED, `AMCD_ADDR_OPEN};
  logic [7:0] route_tab [4] = '{8'h20, 8'h08, 8'h40, 8'h10};

  always #10 clock = ~clock;

  amcd_top #(.SOFT_MUTE_CYC(SOFT), .HARD_MUTE_CYC(HARD)) DUT (
    .clock(clock), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .standby_mode_pin(standby_mode_pin), .addr_strap_pin(addr_strap_pin), .vp_above_10v(vp_above_10v),
    .vp_above_low(vp_above_low), .vp_above_6v(vp_above_6v), .clip_2pct(clip_2pct), .clip_5pct(clip_5pct),
    .clip_10pct(clip_10pct), .temp_warn(temp_warn), .load_fault(load_fault), .diag_pin_oe_n(diag_pin_oe_n),
    .stb_clip_oe_n(stb_clip_oe_n), .amp_enable(amp_enable), .hard_mute(hard_mute), .mute_front(mute_front),
    .mute_rear(mute_rear), .bias_reduced(bias_reduced), .ripple_filter_pin(ripple_filter_pin),
    .low_quiescent(low_quiescent), .bus_lines_loaded(bus_lines_loaded), .gain_front_low(gain_front_low),
    .gain_rear_low(gain_rear_low), .bus_addr(bus_addr), .addr_valid(addr_valid), .legacy_mode(legacy_mode));

  amcd_host host (.clock(clock), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask

  task automatic rdc(input logic [3:0] idx, input logic [7:0] e);
    host.rd(idx, q);
    chk("register byte", e, q);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic conclude();
    if (n_mismatch == 0 && cmp_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    cyc(8);
    rst <= 1'b0;
    cyc(6);
    chb("legacy_mode", 1'b1, legacy_mode);
    chb("addr_valid", 1'b0, addr_valid);
    chb("mute_front", 1'b1, mute_front);
    for (int i = 0; i < 5; i++)
    begin
      addr_strap_pin <= strap_tab[i];
      vp_above_6v <= 1'b1;
      cyc(6);
      chk("bus_addr", {1'b0, addr_tab[i]}, {1'b0, bus_addr});
      chb("addr_valid", 1'b1, addr_valid);
      chb("legacy_mode", 1'b0, legacy_mode);
    end
    vp_above_6v <= 1'b0;
    addr_strap_pin <= `AMCD_STRAP_100K;
    cyc(6);
    chk("bus_addr", {1'b0, `AMCD_ADDR_OPEN}, {1'b0, bus_addr});
    vp_above_6v <= 1'b1;
    cyc(6);
    chk("bus_addr", {1'b0, `AMCD_ADDR_100K}, {1'b0, bus_addr});
    chb("low_quiescent", 1'b1, low_quiescent);
    chb("bus_lines_loaded", 1'b0, bus_lines_loaded);
    host.wr(4'h0, 8'h01);
    rdc(4'h0, 8'h00);
    standby_mode_pin <= 2'h1;
    cyc(6);
    chb("diag_pin_oe_n", 1'b0, diag_pin_oe_n);
    chb("low_quiescent", 1'b0, low_quiescent);
    chb("bus_lines_loaded", 1'b1, bus_lines_loaded);
    rdc(4'h6, 8'h80);
    host.wr5(40'h01_00_00_00_00);
    cyc(3);
    chb("diag_pin_oe_n", 1'b1, diag_pin_oe_n);
    chb("amp_enable", 1'b1, amp_enable);
    rdc(4'h6, 8'h00);
    cyc(SOFT + 8);
    chb("mute_front", 1'b0, mute_front);
    // Bias follows gain pair and line-driver selection
    for (int i = 0; i < 4; i++)
    begin
      b1 = (i == 0) ? 8'h84 : (i == 1) ? 8'h80 : 8'h04;
      host.wr5({16'h01_00, (i == 3) ? 8'h20 : (i == 2) ? 8'h40 : 8'h60, b1, 8'h00});
      cyc(3);
      chb("bias_reduced", i == 0, bias_reduced);
      chb("ripple_filter_pin", b1[7], ripple_filter_pin);
      chb("gain_front_low", i != 3, gain_front_low);
      chb("gain_rear_low", i < 2 || i == 3, gain_rear_low);
    end
    // Write with byte lane 0 off must be ignored
    host.sel_val = 4'h0;
    host.wr(4'h3, 8'h84);
    host.sel_val = 4'h1;
    cyc(3);
    chb("ripple_filter_pin", 1'b0, ripple_filter_pin);
    for (int ch = 0; ch < 8; ch++)
    begin
      host.wr5({(ch < 4) ? 8'h01 : (8'h01 | route_tab[ch % 4]), 32'h0});
      clip_2pct <= 4'h1 << (ch % 4);
      cyc(6);
      chb("diag_pin_oe_n", ch >= 4, diag_pin_oe_n);
      chb("stb_clip_oe_n", ch < 4, stb_clip_oe_n);
      clip_2pct <= 4'h0;
      cyc(6);
    end
    for (int lv = 0; lv < 4; lv++)
    begin
      host.wr5({8'h01, 2'(lv), 30'h0});
      clip_2pct <= {4{lv == 0 || lv == 3}};
      clip_5pct <= {4{lv == 1 || lv == 3}};
      clip_10pct <= {4{lv == 2 || lv == 3}};
      cyc(6);
      chb("diag_pin_oe_n", lv == 3, diag_pin_oe_n);
      {clip_2pct, clip_5pct, clip_10pct} <= 12'h000;
      cyc(6);
    end
    // Clip level must be enabled again, else the supply block is not what holds the pin
    host.wr5(40'h01_00_00_00_00);
    clip_2pct <= 4'h1;
    vp_above_10v <= 1'b0;
    cyc(6);
    chb("diag_pin_oe_n", 1'b1, diag_pin_oe_n);
    host.wr5(40'h81_00_00_00_00);
    vp_above_low <= 1'b1;
    cyc(6);
    chb("diag_pin_oe_n", 1'b0, diag_pin_oe_n);
    clip_2pct <= 4'h0;
    vp_above_10v <= 1'b1;
    cyc(6);
    for (int i = 5; i < 10; i++)
      host.rd(4'(i), q);
    host.wr5(40'h01_30_00_00_00);
    load_fault <= 4'h1;
    temp_warn <= 1'b1;
    cyc(6);
    chb("diag_pin_oe_n", 1'b1, diag_pin_oe_n);
    load_fault <= 4'h0;
    temp_warn <= 1'b0;
    cyc(6);
    rdc(4'h5, 8'h01);
    for (int i = 6; i < 9; i++)
      rdc(4'(i), 8'h00);
    rdc(4'h5, 8'h01);
    for (int i = 6; i < 9; i++)
      rdc(4'(i), 8'h00);
    rdc(4'h9, 8'h01);
    rdc(4'h5, 8'h00);
    host.wr5(40'h01_00_00_00_00);
    load_fault <= 4'hc;
    cyc(6);
    chb("diag_pin_oe_n", 1'b0, diag_pin_oe_n);
    load_fault <= 4'h0;
    cyc(6);
    chb("diag_pin_oe_n", 1'b1, diag_pin_oe_n);
    host.wr5(40'h01_04_00_00_00);
    cyc(SOFT / 2);
    chb("mute_front", 1'b0, mute_front);
    cyc(SOFT);
    chb("mute_front", 1'b1, mute_front);
    chb("mute_rear", 1'b0, mute_rear);
    host.wr5(40'h01_01_00_00_00);
    cyc(4);
    chb("hard_mute", 1'b1, hard_mute);
    chb("mute_rear", 1'b1, mute_rear);
    host.wr5(40'h01_00_60_84_00);
    cyc(SOFT / 2);
    chb("mute_rear", 1'b1, mute_rear);
    cyc(SOFT);
    chb("mute_rear", 1'b0, mute_rear);
    standby_mode_pin <= 2'h0;
    cyc(5);
    chb("hard_mute", 1'b1, hard_mute);
    chb("amp_enable", 1'b1, amp_enable);
    cyc(HARD + 8);
    chb("amp_enable", 1'b0, amp_enable);
    standby_mode_pin <= 2'h1;
    cyc(6);
    // A stale start bit must not restart the amplifier across the power-on reset
    chb("amp_enable", 1'b0, amp_enable);
    for (int i = 0; i < 5; i++)
      rdc(4'(i), 8'h00);
    standby_mode_pin <= 2'h0;
    addr_strap_pin <= `AMCD_STRAP_LEGACY;
    cyc(6);
    chb("legacy_mode", 1'b1, legacy_mode);
    standby_mode_pin <= 2'h1;
    cyc(6);
    chb("amp_enable", 1'b1, amp_enable);
    standby_mode_pin <= 2'h2;
    cyc(SOFT / 2);
    chb("mute_front", 1'b1, mute_front);
    cyc(SOFT);
    chb("mute_front", 1'b0, mute_front);
    standby_mode_pin <= 2'h1;
    cyc(SOFT + 8);
    chb("mute_front", 1'b1, mute_front);
    standby_mode_pin <= 2'h0;
    cyc(HARD + 8);
    chb("amp_enable", 1'b0, amp_enable);
    standby_mode_pin <= 2'h2;
    cyc(SOFT + 8);
    chb("amp_enable", 1'b1, amp_enable);
    standby_mode_pin <= 2'h0;
    cyc(5);
    chb("hard_mute", 1'b1, hard_mute);
    chb("amp_enable", 1'b1, amp_enable);
    cyc(HARD + 8);
    chb("amp_enable", 1'b0, amp_enable);
    conclude();
  end

  // Whole sequence needs under two thousand cycles; this span is far beyond it
  initial
  begin
    cyc(20000);
    n_mismatch++;
    conclude();
  end
endmodule
